// ==== design/hpp_host.sv ====
// Host end of the programming port: software-driven register transfers to the device.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module hpp_host #(
  parameter int TIMEOUT_CYC = hpp_pkg::HOST_TIMEOUT_CYC,
  parameter int SETTLE_CYC = hpp_pkg::PLL_SETTLE_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  hpp_if.host hp,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
    hpp_pkg::hpp_host_state_t state;
    logic [15:0] cnt;
    logic [4:0] ctrl;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic tmo;
    logic refused;
    logic seen_low;
    logic [15:0] settle;
    logic [3:0] hdiv;
    logic hclk;
    logic rst_n;
    logic cs_n;
    logic ds_n;
    logic wd;
    logic doe;
    logic ssel_n;
    logic sdi;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic byte_idx;
    logic [15:0] rd;
  } hpp_host_reg_t;

  hpp_host_reg_t q;
  hpp_host_reg_t n;
  logic ack_n;
  logic [15:0] din;
  logic tick;
  logic rise;
  logic fall;
  logic rd_op;
  logic fin;

  assign {ack_n, din} = q.s2;
  assign tick = q.hdiv == 4'(hpp_pkg::HCLK_HALF_CYC - 1);
  assign rise = tick && !q.hclk;
  assign fall = tick && q.hclk;
  assign rd_op = q.ctrl[hpp_pkg::C_READ];

  always_comb begin
    n = q;
    fin = 1'b0;
    n.s1 = {hp.transfer_acknowledge_n, hp.data};
    n.s2 = q.s1;
    n.hdiv = tick ? 4'h0 : q.hdiv + 4'h1;
    n.hclk = tick ? !q.hclk : q.hclk;
    if (q.settle != 16'h0000) begin
      n.settle = q.settle - 16'h0001;
    end
    // Clears come first so that a flag raised in the same cycle survives.
    if (reg_wr && reg_addr == hpp_pkg::R_STATUS) begin
      n.done = q.done && !reg_wdata[hpp_pkg::S_DONE];
      n.tmo = q.tmo && !reg_wdata[hpp_pkg::S_TIMEOUT];
      n.refused = q.refused && !reg_wdata[hpp_pkg::S_REFUSED];
    end
    case (q.state)
      hpp_pkg::H_RESET: begin
        n.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(hpp_pkg::RESET_PULSE_CYC - 1)) begin
          n.rst_n = 1'b1;
          n.state = hpp_pkg::H_IDLE;
        end
      end
      hpp_pkg::H_IDLE: begin
        if (reg_wr && reg_addr == hpp_pkg::R_CTRL && reg_wdata[hpp_pkg::C_GO]) begin
          n.ctrl = reg_wdata[4:0];
          n.cnt = 16'h0000;
          n.seen_low = 1'b0;
          if (q.addr >= hpp_pkg::ADDR_HANG_LO || (q.settle != 16'h0000 &&
              q.addr >= hpp_pkg::ADDR_PROT_LO && q.addr <= hpp_pkg::ADDR_PROT_HI)) begin
            n.refused = 1'b1;
            fin = 1'b1;
          end else if (reg_wdata[hpp_pkg::C_SERIAL]) begin
            n.sh = q.addr;
            n.byte_idx = 1'b0;
            n.state = hpp_pkg::H_SER_START;
          end else begin
            n.cs_n = 1'b0;
            n.ds_n = reg_wdata[hpp_pkg::C_ACK_MODE] ? 1'b0 : !reg_wdata[hpp_pkg::C_READ];
            n.wd = reg_wdata[hpp_pkg::C_READ];
            n.doe = !reg_wdata[hpp_pkg::C_READ];
            n.state = hpp_pkg::H_WAIT;
          end
        end
      end
      hpp_pkg::H_WAIT: begin
        n.cnt = q.cnt + 16'h0001;
        if (!ack_n) begin
          n.seen_low = 1'b1;
        end
        // Strobes stay on until the device reports completion or TIMEOUT_CYC cycles pass.
        if (q.ctrl[hpp_pkg::C_ACK_MODE] ? !ack_n : (q.seen_low && ack_n)) begin
          if (rd_op) begin
            n.rdata = q.ctrl[hpp_pkg::C_WIDE] ? din : {8'h00, din[7:0]};
          end
          fin = 1'b1;
        end else if (q.cnt == 16'(TIMEOUT_CYC - 1)) begin
          n.tmo = 1'b1;
          fin = 1'b1;
        end
        if (fin) begin
          n.cs_n = 1'b1;
          n.ds_n = 1'b1;
          n.wd = 1'b1;
          n.doe = 1'b0;
          if (!rd_op && q.addr == hpp_pkg::A_CLK_CTRL &&
              q.wdata[hpp_pkg::CLK_MULT_HI:0] != '0) begin
            n.settle = 16'(SETTLE_CYC);
          end
        end
      end
      hpp_pkg::H_SER_START: begin
        if (fall) begin
          n.ssel_n = 1'b0;
          n.sdi = q.sh[7];
          n.sh = {q.sh[6:0], 1'b0};
          n.bitn = 4'h0;
          n.state = hpp_pkg::H_SER_BIT;
        end
      end
      hpp_pkg::H_SER_BIT: begin
        if (rise) begin
          n.bitn = q.bitn + 4'h1;
        end else if (fall) begin
          if (q.bitn == 4'(hpp_pkg::BYTE_BITS)) begin
            n.ssel_n = 1'b1;
            n.state = hpp_pkg::H_SER_GAP;
          end else begin
            n.sdi = q.sh[7];
            n.sh = {q.sh[6:0], 1'b0};
          end
        end
      end
      hpp_pkg::H_SER_GAP: begin
        if (fall) begin
          if (!q.byte_idx) begin
            n.byte_idx = 1'b1;
            n.sh = q.wdata[7:0];
            n.state = hpp_pkg::H_SER_START;
          end else begin
            fin = 1'b1;
          end
        end
      end
      default: n.state = hpp_pkg::H_IDLE;
    endcase
    if (fin) begin
      n.done = 1'b1;
      n.state = hpp_pkg::H_IDLE;
    end
    if (reg_wr && reg_addr == hpp_pkg::R_ADDR && q.state == hpp_pkg::H_IDLE) begin
      n.addr = reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == hpp_pkg::R_WDATA && q.state == hpp_pkg::H_IDLE) begin
      n.wdata = reg_wdata;
    end
    n.rd = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        hpp_pkg::R_CTRL: n.rd = {11'h000, q.ctrl};
        hpp_pkg::R_ADDR: n.rd = {8'h00, q.addr};
        hpp_pkg::R_WDATA: n.rd = q.wdata;
        hpp_pkg::R_STATUS: n.rd = {11'h000, q.settle != 16'h0000, q.refused, q.tmo, q.done,
                                   q.state != hpp_pkg::H_IDLE};
        hpp_pkg::R_RDATA: n.rd = q.rdata;
        default: n.rd = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.ds_n <= 1'b1;
      q.wd <= 1'b1;
      q.ssel_n <= 1'b1;
      q.s1 <= 17'h1FFFF;
      q.s2 <= 17'h1FFFF;
    end else begin
      q <= n;
    end
  end

  assign hp.host_port_clock = q.hclk;
  assign hp.dev_reset_n = q.rst_n;
  assign hp.mode_ack = q.ctrl[hpp_pkg::C_ACK_MODE];
  assign hp.mode_wide = q.ctrl[hpp_pkg::C_WIDE];
  assign hp.cs_n = q.cs_n;
  assign hp.data_strobe_n = q.ds_n;
  assign hp.write_dir = q.wd;
  assign hp.addr = q.addr;
  assign hp.host_data_o = q.wdata;
  assign hp.host_data_oe = q.doe;
  assign hp.serial_select_n = q.ssel_n;
  assign hp.serial_data_in = q.sdi;
  assign reg_rdata = q.rd;
endmodule

// ==== design/hpp_pkg.sv ====
// Shared constants and types for the host programming port.
package hpp_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam logic [7:0] ADDR_HANG_LO = 8'hE8;
  localparam logic [7:0] ADDR_PROT_LO = 8'h68;
  localparam logic [7:0] ADDR_PROT_HI = 8'hE7;
  localparam logic [7:0] A_CLK_CTRL = 8'h00;
  localparam logic [7:0] A_COEF_START = 8'h01;
  localparam logic [7:0] A_COEF_STOP = 8'h02;
  localparam logic [7:0] A_COEF_DATA = 8'h03;
  localparam logic [7:0] A_FILT_EN = 8'h04;
  localparam int CLK_MULT_HI = 4;
  localparam int CLK_CTRL_W = 7;
  localparam int FILT_DECIM_BIT = 0;
  localparam int FILT_CHAN_BIT = 1;
  localparam logic [15:0] COEF_INVALID = 16'h0000;
  localparam int SYS_PERIOD_NS = 5;
  localparam int SYS_CLK_MHZ = 200;
  localparam int PLL_SETTLE_MIN_US = 50;
  localparam int PLL_SETTLE_MAX_US = 200;
  localparam int PLL_SETTLE_MIN_CYC = PLL_SETTLE_MIN_US * SYS_CLK_MHZ;
  localparam int PLL_SETTLE_MAX_CYC = PLL_SETTLE_MAX_US * SYS_CLK_MHZ;
  localparam int RESET_PULSE_NS = 30;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int ACCESS_CYC = 2;
  localparam int DONE_HOLD_CYC = 8;
  localparam int BYTE_BITS = 8;
  localparam int HCLK_HALF_CYC = 2;
  localparam int HOST_TIMEOUT_CYC = 1000;
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_ADDR = 3'h1;
  localparam logic [2:0] R_WDATA = 3'h2;
  localparam logic [2:0] R_STATUS = 3'h3;
  localparam logic [2:0] R_RDATA = 3'h4;
  localparam int C_GO = 0;
  localparam int C_READ = 1;
  localparam int C_SERIAL = 2;
  localparam int C_ACK_MODE = 3;
  localparam int C_WIDE = 4;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_TIMEOUT = 2;
  localparam int S_REFUSED = 3;
  localparam int S_SETTLING = 4;
  typedef enum logic [1:0] {D_IDLE = 2'b00, D_ACC = 2'b01, D_DONE = 2'b10} hpp_dev_state_t;
  typedef enum logic [2:0] {
    H_RESET = 3'b000, H_IDLE = 3'b001, H_WAIT = 3'b010,
    H_SER_START = 3'b011, H_SER_BIT = 3'b100, H_SER_GAP = 3'b101
  } hpp_host_state_t;
endpackage

// ==== design/hpp_if.sv ====
// Pins between the programming host and the device, with the shared wires resolved.
`timescale 1ns/1ps
interface hpp_if;
  logic host_port_clock;
  logic dev_reset_n;
  logic mode_ack;
  logic mode_wide;
  logic cs_n;
  logic data_strobe_n;
  logic write_dir;
  logic [7:0] addr;
  logic [15:0] host_data_o;
  logic host_data_oe;
  logic [15:0] dev_data_o;
  logic [1:0] dev_data_oe;
  logic ack_pull_low;
  logic serial_select_n;
  logic serial_data_in;
  logic [15:0] data;
  logic transfer_acknowledge_n;
  // The pull-up makes a released acknowledge line read high.
  assign transfer_acknowledge_n = ~ack_pull_low;
  assign data[7:0] = host_data_oe ? host_data_o[7:0] :
                     (dev_data_oe[0] ? dev_data_o[7:0] : 8'h00);
  assign data[15:8] = host_data_oe ? host_data_o[15:8] :
                      (dev_data_oe[1] ? dev_data_o[15:8] : 8'h00);
  modport dev (
    input host_port_clock, dev_reset_n, mode_ack, mode_wide, cs_n, data_strobe_n,
    input write_dir, addr, data, serial_select_n, serial_data_in,
    output dev_data_o, dev_data_oe, ack_pull_low
  );
  modport host (
    input data, transfer_acknowledge_n,
    output host_port_clock, dev_reset_n, mode_ack, mode_wide, cs_n, data_strobe_n,
    output write_dir, addr, host_data_o, host_data_oe, serial_select_n, serial_data_in
  );
endinterface

// ==== design/hpp_device.sv ====
// Device end of the host programming port: parallel and serial register access.
//
// Contract
// - Sixteen-bit bus with 8-bit and 16-bit modes.
// - Ready mode: line low during access.
// - Acknowledge mode: line low on completion.
// - Host holds select and strobes until completion.
// - Addresses 0xE8 to 0xFF never complete.
// - Held select starts another access.
// - Each coefficient access advances the pointer.
// - Host sets coefficient start equal stop.
// - Serial select rises after every byte.
// - Host clock under 100 MHz, not above A.
// - Acknowledge line is open drain only.
// - Multiplier off at reset, settles when programmed.
// - Host waits for settling before channel writes; only a parallel A_CLK_CTRL write starts the host's wait.
// - Disabled filters give invalid coefficient readback.
// - Reset pin held low, then 30 ns pulse.
`timescale 1ns/1ps
module hpp_device #(
  parameter int COEF_AW = 4,
  parameter int PLL_SETTLE_CYC = hpp_pkg::PLL_SETTLE_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  hpp_if.dev hp,
  input wire logic [15:0] usr_rdata,
  output logic usr_wr,
  output logic [7:0] usr_addr,
  output logic [15:0] usr_wdata,
  output logic pll_enabled,
  output logic pll_locked
);
  localparam int SW = 33;
  localparam int DEPTH = 1 << COEF_AW;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    hpp_pkg::hpp_dev_state_t state;
    logic [3:0] cnt;
    logic is_read;
    logic ack_pull;
    logic [15:0] dout;
    logic [1:0] doe;
    logic [hpp_pkg::CLK_CTRL_W-1:0] clk_ctrl;
    logic [1:0] filt;
    logic [COEF_AW-1:0] cstart;
    logic [COEF_AW-1:0] cstop;
    logic [COEF_AW-1:0] cptr;
    logic [DEPTH-1:0][15:0] ram;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic sclk_prev;
    logic ser_phase;
    logic [7:0] ser_addr;
    logic pll_on;
    logic [15:0] pll_cnt;
    logic pll_lock;
    logic uwr;
    logic [7:0] uaddr;
    logic [15:0] uwdata;
  } hpp_dev_reg_t;

  hpp_dev_reg_t q;
  hpp_dev_reg_t n;

  logic cs_n;
  logic ds_n;
  logic wd;
  logic sclk;
  logic ssel_n;
  logic sdi;
  logic rst_pin_n;
  logic mack;
  logic mwide;
  logic [7:0] a;
  logic [15:0] d;
  logic req_active;
  logic req_read;
  logic wr_en;
  logic [7:0] wr_a;
  logic [15:0] wr_d;
  logic [15:0] rd_val;
  logic [COEF_AW-1:0] cnext;
  logic [7:0] sbyte;

  assign {cs_n, ds_n, wd, sclk, ssel_n, sdi, rst_pin_n, mack, mwide, a, d} = q.s2;
  assign cnext = (q.cptr == q.cstop) ? q.cstart : q.cptr + 1'b1;
  assign sbyte = {q.sh[6:0], sdi};

  always_comb begin
    n = q;
    n.uwr = 1'b0;
    n.s1 = {hp.cs_n, hp.data_strobe_n, hp.write_dir, hp.host_port_clock, hp.serial_select_n,
            hp.serial_data_in, hp.dev_reset_n, hp.mode_ack, hp.mode_wide, hp.addr, hp.data};
    n.s2 = q.s1;
    // Acknowledge mode: strobe plus direction; ready mode: separate read and write strobes.
    req_active = !cs_n && (mack ? !ds_n : (!ds_n || !wd));
    req_read = mack ? wd : !ds_n;
    wr_en = 1'b0;
    wr_a = a;
    wr_d = mwide ? d : {8'h00, d[7:0]};
    case (a)
      hpp_pkg::A_CLK_CTRL: rd_val = {{(16 - hpp_pkg::CLK_CTRL_W){1'b0}}, q.clk_ctrl};
      hpp_pkg::A_COEF_START: rd_val = {{(16 - COEF_AW){1'b0}}, q.cstart};
      hpp_pkg::A_COEF_STOP: rd_val = {{(16 - COEF_AW){1'b0}}, q.cstop};
      hpp_pkg::A_COEF_DATA: rd_val = (q.filt == 2'b00) ? hpp_pkg::COEF_INVALID : q.ram[q.cptr];
      hpp_pkg::A_FILT_EN: rd_val = {14'h0000, q.filt};
      default: rd_val = usr_rdata;
    endcase
    case (q.state)
      hpp_pkg::D_IDLE: begin
        n.ack_pull = 1'b0;
        n.doe = 2'b00;
        if (req_active) begin
          n.state = hpp_pkg::D_ACC;
          n.cnt = 4'h0;
          n.is_read = req_read;
          n.ack_pull = !mack;
        end
      end
      hpp_pkg::D_ACC: begin
        if (!req_active) begin
          // An access abandoned early does nothing.
          n.state = hpp_pkg::D_IDLE;
          n.ack_pull = 1'b0;
        end else if (a >= hpp_pkg::ADDR_HANG_LO) begin
          n.cnt = 4'h0;
        end else if (q.cnt == 4'(hpp_pkg::ACCESS_CYC - 1)) begin
          n.state = hpp_pkg::D_DONE;
          n.cnt = 4'h0;
          n.ack_pull = mack;
          if (q.is_read) begin
            n.dout = mwide ? rd_val : {8'h00, rd_val[7:0]};
            n.doe = mwide ? 2'b11 : 2'b01;
            if (a == hpp_pkg::A_COEF_DATA) begin
              n.cptr = cnext;
            end
          end else begin
            wr_en = 1'b1;
          end
        end else begin
          n.cnt = q.cnt + 4'h1;
        end
      end
      hpp_pkg::D_DONE: begin
        n.cnt = q.cnt + 4'h1;
        if (!req_active || q.cnt == 4'(hpp_pkg::DONE_HOLD_CYC - 1)) begin
          // A select still held when this ends starts a fresh access from idle.
          n.state = hpp_pkg::D_IDLE;
          n.ack_pull = 1'b0;
          n.doe = 2'b00;
        end
      end
      default: n.state = hpp_pkg::D_IDLE;
    endcase
    n.sclk_prev = sclk;
    if (ssel_n) begin
      n.bitn = 3'h0;
    end else if (sclk && !q.sclk_prev) begin
      n.sh = sbyte;
      n.bitn = q.bitn + 3'h1;
      if (q.bitn == 3'(hpp_pkg::BYTE_BITS - 1)) begin
        n.ser_phase = !q.ser_phase;
        if (!q.ser_phase) begin
          n.ser_addr = sbyte;
        end else if (!wr_en) begin
          wr_en = 1'b1;
          wr_a = q.ser_addr;
          wr_d = {8'h00, sbyte};
        end
      end
    end
    if (wr_en) begin
      case (wr_a)
        hpp_pkg::A_CLK_CTRL: begin
          n.clk_ctrl = wr_d[hpp_pkg::CLK_CTRL_W-1:0];
          n.pll_on = wr_d[hpp_pkg::CLK_MULT_HI:0] != '0;
          n.pll_cnt = 16'h0000;
          n.pll_lock = 1'b0;
        end
        hpp_pkg::A_COEF_START: begin
          n.cstart = wr_d[COEF_AW-1:0];
          n.cptr = wr_d[COEF_AW-1:0];
        end
        hpp_pkg::A_COEF_STOP: n.cstop = wr_d[COEF_AW-1:0];
        hpp_pkg::A_COEF_DATA: begin
          n.ram[q.cptr] = wr_d;
          n.cptr = cnext;
        end
        hpp_pkg::A_FILT_EN: n.filt = {wr_d[hpp_pkg::FILT_CHAN_BIT], wr_d[hpp_pkg::FILT_DECIM_BIT]};
        default: begin
          n.uwr = 1'b1;
          n.uaddr = wr_a;
          n.uwdata = wr_d;
        end
      endcase
    end else if (q.pll_on && !q.pll_lock) begin
      if (q.pll_cnt == 16'(PLL_SETTLE_CYC - 1)) begin
        n.pll_lock = 1'b1;
      end else begin
        n.pll_cnt = q.pll_cnt + 16'h0001;
      end
    end
    if (!rst_pin_n) begin
      // The pin synchroniser keeps running, or the release of the pin would never be seen.
      n = '0;
      n.s2 = q.s1;
      n.s1 = {hp.cs_n, hp.data_strobe_n, hp.write_dir, hp.host_port_clock, hp.serial_select_n,
              hp.serial_data_in, hp.dev_reset_n, hp.mode_ack, hp.mode_wide, hp.addr, hp.data};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Open drain: only a pull-low enable leaves the device.
  assign hp.ack_pull_low = q.ack_pull;
  assign hp.dev_data_o = q.dout;
  assign hp.dev_data_oe = q.doe;
  assign usr_wr = q.uwr;
  assign usr_addr = q.uaddr;
  assign usr_wdata = q.uwdata;
  assign pll_enabled = q.pll_on;
  assign pll_locked = q.pll_lock;
endmodule

// ==== bench/hpp_props.sv ====
// Concurrent checks on the pins between the host and device ends of the programming port.
`timescale 1ns/1ps
module hpp_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic host_port_clock,
  input wire logic mode_ack,
  input wire logic mode_wide,
  input wire logic cs_n,
  input wire logic write_dir,
  input wire logic [7:0] addr,
  input wire logic [1:0] dev_data_oe,
  input wire logic ack_pull_low,
  input wire logic serial_select_n
);
  logic [3:0] ser_cnt_q;
  logic hpc_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Counts serial clock rises inside one select window.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_cnt_q <= 4'h0;
      hpc_q <= 1'b0;
    end else begin
      hpc_q <= host_port_clock;
      if (serial_select_n) begin
        ser_cnt_q <= 4'h0;
      end else if (host_port_clock && !hpc_q) begin
        ser_cnt_q <= ser_cnt_q + 4'h1;
      end
    end
  end
  sequence par_start;
    $fell(cs_n) && addr < 8'hE8;
  endsequence
  sequence ready_pulse;
    ack_pull_low ##[1:6] !ack_pull_low;
  endsequence
  sequence rd_done;
    (!cs_n) [*3] ##1 (!cs_n && mode_ack && write_dir && ack_pull_low) [*2];
  endsequence
  ready_pulse_a: assert property (!mode_ack ##0 par_start |-> ##[1:6] ready_pulse)
    else $error("ready line did not go low and then release");
  ack_done_a: assert property (mode_ack ##0 par_start |-> ##[1:12] ack_pull_low)
    else $error("no acknowledge after access");
  hang_addr_a: assert property (!cs_n |-> addr < 8'hE8)
    else $error("host selected a hanging address");
  req_hold_a: assert property (!cs_n && !$past(cs_n) |-> $stable(addr) && $stable(write_dir))
    else $error("request changed before completion");
  drop_done_a: assert property ($rose(cs_n) |-> $past(ack_pull_low) == mode_ack)
    else $error("select dropped before completion");
  narrow_lane_a: assert property ((!mode_wide) [*5] |-> !dev_data_oe[1])
    else $error("upper lane driven in 8-bit mode");
  read_lane_a: assert property (rd_done |-> dev_data_oe[0])
    else $error("read data not driven during completion");
  ser_byte_a: assert property ($rose(serial_select_n) |-> ser_cnt_q == 4'h8)
    else $error("serial select window not eight clocks");
  ack_idle_a: assert property ((cs_n && serial_select_n) [*6] |-> !ack_pull_low)
    else $error("acknowledge line held low while idle");
endmodule

// ==== bench/tb_top.sv ====
// Bench: host and device ends joined, plus a second device driven raw at its pins.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] W = 16'h0019;
  localparam logic [15:0] R = 16'h001B;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] usr_rdata = 16'h0000;
  logic [15:0] reg_rdata, usr_wdata, st, v, d;
  logic [15:0] cf [4];
  logic [7:0] usr_addr, a;
  logic usr_wr, usr_wr2, pll_enabled, pll_locked;
  int seed = 12868;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int nwr = 0;
  int nwr2 = 0;
  int nack2 = 0;
  int exp_wr = 0;
  int base;
  hpp_if hp();
  hpp_if hb();
  always #2.5 sys_clk = ~sys_clk;
  hpp_host #(.TIMEOUT_CYC(50), .SETTLE_CYC(60)) i_hpp_host (.sys_clk(sys_clk), .arst_n(arst_n),
    .hp(hp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  hpp_device #(.COEF_AW(4), .PLL_SETTLE_CYC(40)) i_hpp_device (.sys_clk(sys_clk),
    .arst_n(arst_n), .hp(hp), .usr_rdata(usr_rdata), .usr_wr(usr_wr), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .pll_enabled(pll_enabled), .pll_locked(pll_locked));
  hpp_device i_hpp_device_b (.sys_clk(sys_clk), .arst_n(arst_n), .hp(hb),
    .usr_rdata(16'h0000), .usr_wr(usr_wr2), .usr_addr(), .usr_wdata(), .pll_enabled(),
    .pll_locked());
  hpp_props i_hpp_props (.sys_clk(sys_clk), .arst_n(arst_n),
    .host_port_clock(hp.host_port_clock), .mode_ack(hp.mode_ack), .mode_wide(hp.mode_wide),
    .cs_n(hp.cs_n), .write_dir(hp.write_dir), .addr(hp.addr), .dev_data_oe(hp.dev_data_oe),
    .ack_pull_low(hp.ack_pull_low), .serial_select_n(hp.serial_select_n));
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_cnt(input string what, input int e, input int g);
    compares++;
    if (g != e) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask
  function automatic logic [15:0] lane(input logic w, input logic [15:0] x);
    return w ? x : {8'h00, x[7:0]};
  endfunction
  function automatic logic [15:0] ctl(input logic r, input logic s, input logic k, input logic w);
    return {11'h000, w, k, s, r, 1'b1};
  endfunction
  task automatic wr(input logic [2:0] ad, input logic [15:0] dt);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] ad, output logic [15:0] dt);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    dt = reg_rdata;
  endtask
  task automatic xfer(input logic [15:0] c, input logic [7:0] ad, input logic [15:0] dt);
    int n;
    n = 0;
    wr(hpp_pkg::R_STATUS, 16'h000E);
    wr(hpp_pkg::R_ADDR, {8'h00, ad});
    wr(hpp_pkg::R_WDATA, dt);
    wr(hpp_pkg::R_CTRL, c);
    st = 16'h0001;
    while (st[hpp_pkg::S_BUSY] !== 1'b0 && n < 100) begin
      rd(hpp_pkg::R_STATUS, st);
      n++;
    end
    chk_cnt("busy polls", 1, (n < 100) ? 1 : 0);
    repeat (4) @(posedge sys_clk);
  endtask
  // Raw pins of the second device: ack mode, strobe follows select.
  task automatic raw(input logic c, input logic [7:0] ad, input logic rdn);
    hb.cs_n <= c;
    hb.data_strobe_n <= c;
    hb.write_dir <= rdn;
    hb.addr <= ad;
    hb.host_data_oe <= !c && !rdn;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (usr_wr === 1'b1) nwr++;
    if (usr_wr2 === 1'b1) nwr2++;
    if (hb.ack_pull_low === 1'b1) nack2++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    hb.host_port_clock = 1'b0;
    hb.dev_reset_n = 1'b1;
    hb.mode_ack = 1'b1;
    hb.mode_wide = 1'b1;
    hb.serial_select_n = 1'b1;
    hb.serial_data_in = 1'b0;
    hb.host_data_o = 16'h0000;
    raw(1'b1, 8'h00, 1'b1);
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk_val("ack idle", 16'h0001, {15'h0, hp.transfer_acknowledge_n});
    chk_val("pll reset", 16'h0000, {14'h0, pll_enabled, pll_locked});
    for (int m = 0; m < 8; m++) begin
      a = 8'h10 + 8'($unsigned($random(seed)) % 88);
      d = 16'($random(seed));
      xfer(ctl(1'b0, 1'b0, m[0], m[1]), a, d);
      exp_wr++;
      chk_val("wr addr", {8'h00, a}, {8'h00, usr_addr});
      chk_val("wr data", lane(m[1], d), usr_wdata);
      usr_rdata <= 16'($random(seed));
      xfer(ctl(1'b1, 1'b0, m[0], m[1]), a, 16'h0000);
      rd(hpp_pkg::R_RDATA, v);
      chk_val("rd data", lane(m[1], usr_rdata), v);
      if (m[2]) begin
        xfer(ctl(1'b0, 1'b1, 1'b0, 1'b0), a ^ 8'h01, d);
        exp_wr++;
        chk_val("ser addr", {8'h00, a ^ 8'h01}, {8'h00, usr_addr});
        chk_val("ser data", {8'h00, d[7:0]}, usr_wdata);
      end
      chk_cnt("writes", exp_wr, nwr);
    end
    $display("test transfers done");
    xfer(W, 8'hE7, 16'hA5C3);
    exp_wr++;
    chk_val("edge addr", 16'h00E7, {8'h00, usr_addr});
    for (int k = 0; k < 2; k++) begin
      xfer(ctl(1'b0, 1'b0, k[0], 1'b1), k[0] ? 8'hFF : 8'hE8, 16'h1234);
      chk_val("refused", 16'h0001, {15'h0, st[hpp_pkg::S_REFUSED]});
    end
    chk_cnt("writes", exp_wr, nwr);
    $display("test limits done");
    xfer(W, hpp_pkg::A_CLK_CTRL, 16'h0005);
    chk_val("pll on", 16'h0002, {14'h0, pll_enabled, pll_locked});
    chk_val("settling", 16'h0001, {15'h0, st[hpp_pkg::S_SETTLING]});
    xfer(W, 8'h68, 16'h0001);
    chk_val("early chan", 16'h0001, {15'h0, st[hpp_pkg::S_REFUSED]});
    repeat (60) @(posedge sys_clk);
    chk_val("pll lock", 16'h0003, {14'h0, pll_enabled, pll_locked});
    xfer(W, 8'h68, 16'h0001);
    exp_wr++;
    chk_val("chan addr", 16'h0068, {8'h00, usr_addr});
    xfer(W, hpp_pkg::A_CLK_CTRL, 16'h0000);
    chk_val("pll off", 16'h0000, {15'h0, pll_enabled});
    repeat (60) @(posedge sys_clk);
    $display("test clock done");
    xfer(W, hpp_pkg::A_FILT_EN, 16'h0003);
    xfer(W, hpp_pkg::A_COEF_START, 16'h0002);
    xfer(W, hpp_pkg::A_COEF_STOP, 16'h0005);
    for (int k = 0; k < 4; k++) begin
      cf[k] = 16'($random(seed));
      xfer(W, hpp_pkg::A_COEF_DATA, cf[k]);
    end
    for (int k = 0; k < 4; k++) begin
      xfer(R, hpp_pkg::A_COEF_DATA, 16'h0000);
      rd(hpp_pkg::R_RDATA, v);
      chk_val("coef", cf[k], v);
    end
    d = 16'($random(seed));
    xfer(W, hpp_pkg::A_COEF_START, 16'h0007);
    xfer(W, hpp_pkg::A_COEF_STOP, 16'h0007);
    xfer(W, hpp_pkg::A_COEF_DATA, ~d);
    xfer(W, hpp_pkg::A_COEF_DATA, d);
    xfer(R, hpp_pkg::A_COEF_DATA, 16'h0000);
    rd(hpp_pkg::R_RDATA, v);
    chk_val("coef single", d, v);
    xfer(W, hpp_pkg::A_COEF_START, 16'h0003);
    xfer(W, hpp_pkg::A_COEF_STOP, 16'h0003);
    xfer(R, hpp_pkg::A_COEF_DATA, 16'h0000);
    rd(hpp_pkg::R_RDATA, v);
    chk_val("coef kept", cf[1], v);
    xfer(W, hpp_pkg::A_FILT_EN, 16'h0000);
    xfer(R, hpp_pkg::A_COEF_DATA, 16'h0000);
    rd(hpp_pkg::R_RDATA, v);
    chk_val("coef off", hpp_pkg::COEF_INVALID, v);
    $display("test coef done");
    hb.host_data_o <= 16'($random(seed));
    raw(1'b0, 8'h20, 1'b0);
    repeat (60) @(posedge sys_clk);
    raw(1'b1, 8'h20, 1'b0);
    chk_val("repeat", 16'h0001, {15'h0, nwr2 >= 2});
    repeat (10) @(posedge sys_clk);
    base = nack2;
    raw(1'b0, 8'hF0, 1'b1);
    repeat (60) @(posedge sys_clk);
    raw(1'b1, 8'hF0, 1'b1);
    chk_cnt("hang ack", base, nack2);
    chk_cnt("writes", exp_wr, nwr);
    $display("test raw done");
    end_sim();
  end
endmodule
